// ==== logic/bmf_avalon_regs.sv ====
// Avalon-MM slave holding the flag offsets and showing FIFO status.
// Assumes a master that holds its request until waitrequest is low.
`timescale 1ns/1ps
`include "bmf_consts.svh"
module bmf_avalon_regs
    import bmf_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    input  bmf_status_t      status,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [9:0]  ae_offset,
    output logic      [9:0]  af_offset
);
    logic        next_waitrequest;
    logic [31:0] next_readdata;
    logic [9:0]  next_ae_offset;
    logic [9:0]  next_af_offset;
    logic        req;
    logic        commit;

    // -----------------------------------------------------------------
    // Decode: answer one cycle after the request is seen
    // -----------------------------------------------------------------
    always_comb begin
        req              = avs_read | avs_write;
        commit           = avs_write & ~avs_waitrequest;
        next_waitrequest = ~(req & avs_waitrequest);
        next_readdata    = avs_readdata;
        next_ae_offset   = ae_offset;
        next_af_offset   = af_offset;
        if (avs_read && avs_waitrequest) begin
            case (avs_address)
                `BMF_ADDR_AE_OFFSET: next_readdata = {22'h0, ae_offset};
                `BMF_ADDR_AF_OFFSET: next_readdata = {22'h0, af_offset};
                `BMF_ADDR_STATUS: begin
                    next_readdata = 32'h0000_0000;
                    next_readdata[`BMF_STAT_FLAGS_LSB +: 6] =
                        status[16:11];
                    next_readdata[`BMF_STAT_FILL_LSB +: 11] = status.fill;
                end
                default: next_readdata = `BMF_RDATA_IDLE;
            endcase
        end
        if (commit && avs_address == `BMF_ADDR_AE_OFFSET) begin
            if (avs_byteenable[0]) next_ae_offset[7:0] = avs_writedata[7:0];
            if (avs_byteenable[1]) next_ae_offset[9:8] = avs_writedata[9:8];
        end
        if (commit && avs_address == `BMF_ADDR_AF_OFFSET) begin
            if (avs_byteenable[0]) next_af_offset[7:0] = avs_writedata[7:0];
            if (avs_byteenable[1]) next_af_offset[9:8] = avs_writedata[9:8];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= `BMF_RDATA_IDLE;
            ae_offset       <= `BMF_AE_OFFSET_RST;
            af_offset       <= `BMF_AF_OFFSET_RST;
        end else begin
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= next_readdata;
            ae_offset       <= next_ae_offset;
            af_offset       <= next_af_offset;
        end
    end
endmodule

// ==== logic/bmf_consts.svh ====
// Constants of the bus-matching FIFO read side: register map, reset
// values and status field layout. Included by the register block and the FIFO module.
`ifndef BMF_CONSTS_SVH
`define BMF_CONSTS_SVH

// -------------------------------------------------------------------
// Register byte offsets
// -------------------------------------------------------------------
`define BMF_ADDR_AE_OFFSET 4'h0
`define BMF_ADDR_AF_OFFSET 4'h4
`define BMF_ADDR_STATUS    4'h8

// -------------------------------------------------------------------
// Reset values
// -------------------------------------------------------------------
`define BMF_AE_OFFSET_RST  10'h008
`define BMF_AF_OFFSET_RST  10'h008
`define BMF_RDATA_IDLE     32'h0000_0000

// -------------------------------------------------------------------
// Status register fields
// -------------------------------------------------------------------
`define BMF_STAT_FLAGS_LSB 0
`define BMF_STAT_FILL_LSB  16

`endif

// ==== logic/bmf_fifo_read_side.sv ====
// Bus-matching FIFO: port A writes long words, port B reads them as
// long words, words or bytes; two width-limited bypass mailboxes.
// Assumes both ports and the register bus run on the one clock.
`timescale 1ns/1ps
`include "bmf_consts.svh"
// Summary of operation
// - Long-word mode returns each stored word whole, lanes unchanged.
// - Word mode: two reads on low 18 lines, order set by endian.
// - Byte mode: four reads on low 9 lines, order set by endian.
// - Lines above the selected width carry no data during reads.
// - Endian caught at reset; width selection stays static.
// - Fall-through: ready and first word loaded within three cycles.
// - Narrow modes: empty indication drops only on final piece.
// - Standard mode: empty flag rises soon after write into empty.
// - After a read from full, full flag rises soon after.
// - Narrow modes free a location only on its final piece.
// - Almost-empty follows writes soon; reasserts on final piece.
// - Almost-full follows reads soon; depth is a parameter.
// - A-to-B mailbox limited to the selected port B width.
// - B-to-A mailbox limited to the selected port B width.
// - Per device fill latency stays within four transfer cycles.
// - Per device space latency stays within three transfer cycles.
// - Endian level latched as master reset is released.
// - Remaining pieces come from an auxiliary register.
// - Mail write pulls its flag low; later writes ignored.
module bmf_fifo_read_side
    import bmf_pkg::*;
#(
    parameter int DEPTH = 1024,
    parameter int AW    = $clog2(DEPTH),
    parameter int PW    = AW + 1
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        partial_reset_n,
    input  wire logic        bus_match_select,
    input  wire logic        port_b_size_select,
    input  wire logic        endian_order_select,
    input  wire logic        fall_through_mode,
    input  wire logic        port_a_chip_select_n,
    input  wire logic        port_a_direction,
    input  wire logic        port_a_enable,
    input  wire logic        port_a_mail_select,
    input  wire logic [35:0] port_a_data_in,
    output logic      [35:0] port_a_data_out,
    output logic             port_a_data_oe,
    input  wire logic        port_b_chip_select_n,
    input  wire logic        port_b_direction,
    input  wire logic        port_b_enable,
    input  wire logic        port_b_mail_select,
    input  wire logic [35:0] port_b_data_in,
    output logic      [35:0] port_b_data_out,
    output logic             port_b_data_oe,
    output logic             empty_flag_n,
    output logic             almost_empty_flag_n,
    output logic             full_flag_n,
    output logic             almost_full_flag_n,
    output logic             a_to_b_mail_flag_n,
    output logic             b_to_a_mail_flag_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    bmf_size_t   cfg_size;
    logic        cfg_big;
    logic        cfg_fall_through_mode;
    logic [PW-1:0] wptr, wptr_b, rptr, rptr_a;
    logic [PW-1:0] next_wptr, next_rptr, fill_b, fill_a;
    logic [1:0]  cnt, next_cnt;
    logic [35:0] aux, next_aux, ram_q, next_bout;
    logic [35:0] a2b, b2a, next_a2b, next_b2a, next_aout;
    logic        next_empty_n, next_ae_n, next_full_n, next_af_n;
    logic        next_a2b_n, next_b2a_n;
    logic        a_fifo_wr, a_mail_wr, a_mail_rd, accept;
    logic        b_fifo_rd, b_mail_wr, b_mail_rd, take, last;
    logic [9:0]  ae_offset, af_offset;
    bmf_status_t status;

    // -----------------------------------------------------------------
    // Port decode
    // -----------------------------------------------------------------
    always_comb begin
        a_fifo_wr = ~port_a_chip_select_n & port_a_direction &
                    port_a_enable & ~port_a_mail_select;
        a_mail_wr = ~port_a_chip_select_n & port_a_direction &
                    port_a_enable & port_a_mail_select;
        a_mail_rd = ~port_a_chip_select_n & ~port_a_direction &
                    port_a_enable & port_a_mail_select;
        b_fifo_rd = ~port_b_chip_select_n & port_b_direction &
                    port_b_enable & ~port_b_mail_select;
        b_mail_rd = ~port_b_chip_select_n & port_b_direction &
                    port_b_enable & port_b_mail_select;
        b_mail_wr = ~port_b_chip_select_n & ~port_b_direction &
                    port_b_enable & port_b_mail_select;
        accept    = a_fifo_wr & full_flag_n;
        last      = (cnt == bmf_last(cfg_size));
        // In fall-through mode the flag doubles as output-ready
        take      = b_fifo_rd & empty_flag_n;
    end

    // -----------------------------------------------------------------
    // FIFO pointers, bus matching and flags
    // -----------------------------------------------------------------
    always_comb begin
        next_wptr = wptr + PW'(accept);
        next_rptr = rptr;
        next_cnt  = cnt;
        next_aux  = aux;
        next_bout = port_b_data_out;
        if (cfg_fall_through_mode) begin
            next_empty_n = empty_flag_n;
            if (take && last) begin
                next_rptr    = rptr + PW'(1);
                next_cnt     = 2'h0;
                next_empty_n = 1'b0;
            end else if (take) begin
                next_cnt  = cnt + 2'h1;
                next_bout = bmf_piece(aux, next_cnt, cfg_size, cfg_big);
            end else if (!empty_flag_n && wptr_b != rptr) begin
                next_bout    = bmf_piece(ram_q, 2'h0, cfg_size, cfg_big);
                next_aux     = ram_q;
                next_cnt     = 2'h0;
                next_empty_n = 1'b1;
            end
        end else begin
            if (take) begin
                next_bout = bmf_piece((cnt == 2'h0) ? ram_q : aux, cnt,
                                      cfg_size, cfg_big);
                if (cnt == 2'h0) begin
                    next_aux = ram_q;
                end
                next_cnt = last ? 2'h0 : cnt + 2'h1;
                if (last) begin
                    next_rptr = rptr + PW'(1);
                end
            end
            next_empty_n = (wptr_b != next_rptr);
        end
        if (b_mail_rd) begin
            next_bout = a2b & bmf_mask(cfg_size);
        end
        if (!partial_reset_n) begin
            next_wptr    = '0;
            next_rptr    = '0;
            next_cnt     = 2'h0;
            next_empty_n = 1'b0;
        end
        fill_b      = wptr_b - next_rptr;
        fill_a      = next_wptr - rptr_a;
        next_ae_n   = fill_b > PW'(ae_offset);
        next_full_n = fill_a != PW'(DEPTH);
        next_af_n   = fill_a < PW'(DEPTH) - PW'(af_offset);
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            // Configuration is caught at the release edge of reset
            cfg_big  <= endian_order_select;
            cfg_fall_through_mode <= fall_through_mode;
            cfg_size <= !bus_match_select ? BMF_LONG :
                        port_b_size_select ? BMF_BYTE : BMF_WORD;
            wptr                <= '0;
            wptr_b              <= '0;
            rptr                <= '0;
            rptr_a              <= '0;
            cnt                 <= 2'h0;
            aux                 <= 36'h0_0000_0000;
            port_b_data_out     <= 36'h0_0000_0000;
            port_b_data_oe      <= 1'b0;
            empty_flag_n        <= 1'b0;
            almost_empty_flag_n <= 1'b0;
            full_flag_n         <= 1'b0;
            almost_full_flag_n  <= 1'b1;
        end else begin
            wptr                <= next_wptr;
            // One-stage hand-over stands in for the cross-port sync
            wptr_b              <= partial_reset_n ? wptr : '0;
            rptr_a              <= partial_reset_n ? rptr : '0;
            rptr                <= next_rptr;
            cnt                 <= next_cnt;
            aux                 <= next_aux;
            port_b_data_out     <= next_bout;
            port_b_data_oe      <= ~port_b_chip_select_n & port_b_direction;
            empty_flag_n        <= next_empty_n;
            almost_empty_flag_n <= next_ae_n;
            full_flag_n         <= next_full_n;
            almost_full_flag_n  <= next_af_n;
        end
    end

    // -----------------------------------------------------------------
    // Mailboxes
    // -----------------------------------------------------------------
    always_comb begin
        next_a2b   = a2b;
        next_b2a   = b2a;
        next_a2b_n = a_to_b_mail_flag_n | b_mail_rd;
        next_b2a_n = b_to_a_mail_flag_n | a_mail_rd;
        next_aout  = port_a_data_out;
        if (a_mail_wr && a_to_b_mail_flag_n) begin
            next_a2b   = port_a_data_in & bmf_mask(cfg_size);
            next_a2b_n = 1'b0;
        end
        if (b_mail_wr && b_to_a_mail_flag_n) begin
            next_b2a   = port_b_data_in & bmf_mask(cfg_size);
            next_b2a_n = 1'b0;
        end
        if (a_mail_rd) begin
            next_aout = b2a & bmf_mask(cfg_size);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            a2b                <= 36'h0_0000_0000;
            b2a                <= 36'h0_0000_0000;
            a_to_b_mail_flag_n <= 1'b1;
            b_to_a_mail_flag_n <= 1'b1;
            port_a_data_out    <= 36'h0_0000_0000;
            port_a_data_oe     <= 1'b0;
        end else begin
            a2b                <= next_a2b;
            b2a                <= next_b2a;
            a_to_b_mail_flag_n <= next_a2b_n;
            b_to_a_mail_flag_n <= next_b2a_n;
            port_a_data_out    <= next_aout;
            port_a_data_oe     <= ~port_a_chip_select_n &
                                  ~port_a_direction;
        end
    end

    // -----------------------------------------------------------------
    // Storage and register bus
    // -----------------------------------------------------------------
    always_comb begin
        status                = '0;
        status.empty_n        = empty_flag_n;
        status.almost_empty_n = almost_empty_flag_n;
        status.full_n         = full_flag_n;
        status.almost_full_n  = almost_full_flag_n;
        status.a_to_b_n       = a_to_b_mail_flag_n;
        status.b_to_a_n       = b_to_a_mail_flag_n;
        status.fill           = 11'(PW'(wptr_b - rptr));
    end

    bmf_ram #(.WIDTH(36), .DEPTH(DEPTH), .AW(AW)) u_ram (
        .clock   (clock),
        .wr_en   (accept),
        .wr_addr (wptr[AW-1:0]),
        .wr_data (port_a_data_in),
        .rd_addr (next_rptr[AW-1:0]),
        .rd_data (ram_q)
    );

    bmf_avalon_regs u_regs (
        .clock           (clock),
        .rst_b           (rst_b),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .status          (status),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .ae_offset       (ae_offset),
        .af_offset       (af_offset)
    );

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence write_into_empty_s;
        accept && wptr == rptr && !empty_flag_n && partial_reset_n;
    endsequence

    sequence quiet_s;
        partial_reset_n [*3];
    endsequence

    endian_hold_a: assert property ($stable(cfg_big) && $stable(cfg_size))
        else $error("configuration changed outside reset");
    empty_rise_a: assert property (!cfg_fall_through_mode ##0 write_into_empty_s
        |-> ##3 empty_flag_n) else $error("empty flag late");
    ready_rise_a: assert property (cfg_fall_through_mode ##0 write_into_empty_s
        ##0 quiet_s |-> ##[1:3] empty_flag_n)
        else $error("output ready late");
    narrow_hold_a: assert property (take && !last && partial_reset_n
        |=> empty_flag_n) else $error("empty dropped mid word");
    free_last_a: assert property (take && !last && partial_reset_n
        |=> $stable(rptr)) else $error("location freed mid word");
    full_rise_a: assert property (!full_flag_n && take && last
        && partial_reset_n |-> ##3 full_flag_n)
        else $error("full flag late");
    long_word_a: assert property (!cfg_fall_through_mode && cfg_size == BMF_LONG
        && take && !b_mail_rd |=> port_b_data_out == $past(ram_q))
        else $error("long word altered");
    upper_lines_a: assert property (cfg_size != BMF_LONG
        |-> (port_b_data_out & ~bmf_mask(cfg_size)) == 36'h0_0000_0000)
        else $error("upper lines driven");
    mail_flag_a: assert property (a_mail_wr && a_to_b_mail_flag_n
        |=> !a_to_b_mail_flag_n) else $error("mail flag not set");
    mail_ignore_a: assert property (a_mail_wr && !a_to_b_mail_flag_n
        |=> $stable(a2b)) else $error("mail write not ignored");
    mail_width_a: assert property ((b2a & ~bmf_mask(cfg_size))
        == 36'h0_0000_0000) else $error("mailbox too wide");
    count_clear_a: assert property (!partial_reset_n |=> cnt == 2'h0)
        else $error("piece count kept");
endmodule

// ==== logic/bmf_pkg.sv ====
// Types and helpers of the bus-matching FIFO read side.
// Assumes nothing beyond a SystemVerilog compiler.
package bmf_pkg;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {BMF_LONG, BMF_WORD, BMF_BYTE} bmf_size_t;

    typedef struct packed {
        logic        empty_n;
        logic        almost_empty_n;
        logic        full_n;
        logic        almost_full_n;
        logic        a_to_b_n;
        logic        b_to_a_n;
        logic [10:0] fill;
    } bmf_status_t;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Index of the final piece of a long word
    function automatic logic [1:0] bmf_last(bmf_size_t sz);
        case (sz)
            BMF_WORD: return 2'h1;
            BMF_BYTE: return 2'h3;
            default:  return 2'h0;
        endcase
    endfunction

    // Lines that carry data at the selected width
    function automatic logic [35:0] bmf_mask(bmf_size_t sz);
        case (sz)
            BMF_WORD: return 36'h0_0003_FFFF;
            BMF_BYTE: return 36'h0_0000_01FF;
            default:  return 36'hF_FFFF_FFFF;
        endcase
    endfunction

    // Piece idx of long word w, placed on the low lines
    function automatic logic [35:0] bmf_piece(logic [35:0] w,
                                              logic [1:0]  idx,
                                              bmf_size_t   sz,
                                              logic        big);
        logic [35:0] r;
        logic [1:0]  lane;
        r    = 36'h0_0000_0000;
        lane = big ? 2'h3 - idx : idx;
        case (sz)
            BMF_WORD: r[17:0] = (big ^ idx[0]) ? w[35:18] : w[17:0];
            BMF_BYTE: r[8:0]  = w[9*lane +: 9];
            default:  r       = w;
        endcase
        return r;
    endfunction

endpackage

// ==== logic/bmf_ram.sv ====
// Long-word store of the FIFO with a registered read port.
// Assumes one clock; read data is the word at rd_addr one edge later.
`timescale 1ns/1ps
module bmf_ram #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 1024,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clock,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ==== verif/bmf_fifo_read_side_tb_top.sv ====
// Testbench of the FIFO read side: every port B width and endian order.
// Assumes one clock for both ports and the register bus.
`timescale 1ns/1ps
module bmf_fifo_read_side_tb_top;
    logic        clock, rst_b, bm, sz, be, b_cs_n, b_en, b_mail;
    logic        fw, prs_n;
    logic        a_cs_n, a_en, a_mail, ef_n, aef_n, ff_n, aff_n, m1_n;
    logic        avs_read, avs_write, avs_wait;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [35:0] a_data, b_out, m, got;
    logic [35:0] wq[8];
    logic [35:0] expq[$];
    int          num_errors, checks, seed, n;

    bmf_port_a_model u_pa (.clock(clock), .full_flag_n(ff_n), .cs_n(a_cs_n),
        .en(a_en), .mail(a_mail), .data(a_data));
    bmf_fifo_read_side #(.DEPTH(8)) u_dut (
        .clock(clock), .rst_b(rst_b), .partial_reset_n(prs_n),
        .bus_match_select(bm), .port_b_size_select(sz),
        .endian_order_select(be), .fall_through_mode(fw),
        .port_a_chip_select_n(a_cs_n), .port_a_direction(1'b1),
        .port_a_enable(a_en), .port_a_mail_select(a_mail),
        .port_a_data_in(a_data), .port_a_data_out(), .port_a_data_oe(),
        .port_b_chip_select_n(b_cs_n), .port_b_direction(1'b1),
        .port_b_enable(b_en), .port_b_mail_select(b_mail),
        .port_b_data_in(a_data), .port_b_data_out(b_out),
        .port_b_data_oe(), .empty_flag_n(ef_n),
        .almost_empty_flag_n(aef_n), .full_flag_n(ff_n),
        .almost_full_flag_n(aff_n), .a_to_b_mail_flag_n(m1_n),
        .b_to_a_mail_flag_n(), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_wait));

    task automatic chk(string nm, logic [35:0] seen, logic [35:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic av(logic wr, logic [3:0] ad, logic [31:0] wd);
        @(posedge clock);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= ad;
        avs_writedata <= wd;
        do @(posedge clock); while (avs_wait !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic close_out();
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Piece i of long word x in the selected width and order
    function automatic logic [35:0] pc(logic [35:0] x, int i);
        return (x >> ((36 / n) * (be ? n - 1 - i : i))) & m;
    endfunction

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        #200000;
        num_errors++;
        close_out();
    end
    // Standard mode shows the piece after the read edge, fall-through
    // mode shows it before
    always @(posedge clock) begin
        if (b_cs_n === 1'b0 && b_en && !b_mail && ef_n === 1'b1) begin
            got = b_out;
            #1 chk("port_b_data_out", fw ? got : b_out,
                   expq.pop_front());
        end
    end
    initial begin
        {rst_b, bm, sz, be, fw, b_en, b_mail, avs_read, avs_write} = 9'h0;
        seed = 19968;
        num_errors = 0;
        checks = 0;
        {b_cs_n, prs_n} = 2'h3;
        {avs_address, avs_writedata} = 36'h0;
        for (int k = 0; k < 5; k++) begin
            @(posedge clock);
            bm <= (k != 0);
            sz <= (k > 2);
            be <= k[0];
            fw <= k[1];
            rst_b <= 1'b0;
            repeat (4) @(posedge clock);
            rst_b <= 1'b1;
            repeat (2) @(posedge clock);
            n = !bm ? 1 : (sz ? 4 : 2);
            m = (36'h1 << (36 / n)) - 36'h1;
            chk("full_flag_n", ff_n, 1'b1);
            av(1'b1, 4'h0, 32'h2);
            av(1'b1, 4'h4, 32'h2);
            av(1'b0, 4'h0, 32'h0);
            chk("ae_offset", rd, 32'h2);
            av(1'b0, 4'hc, 32'h0);
            chk("unmapped", rd, 32'h0);
            // One piece read, then a flush: the next read starts a word
            wq[0] = 36'({$random(seed), $random(seed)});
            #1 u_pa.send({1'b0, wq[0]});
            while (ef_n !== 1'b1) @(posedge clock);
            {b_cs_n, b_en} <= 2'h1;
            expq.push_back(pc(wq[0], 0));
            @(posedge clock);
            {b_cs_n, b_en, prs_n} <= 3'h4;
            @(posedge clock);
            prs_n <= 1'b1;
            @(posedge clock);
            chk("empty_flag_n", ef_n, 1'b0);
            #1;
            for (int j = 0; j < 8; j++) begin
                wq[j] = 36'({$random(seed), $random(seed)});
                u_pa.send({1'b0, wq[j]});
            end
            while (ff_n !== 1'b0) @(posedge clock);
            repeat (3) @(posedge clock);
            chk("almost_full_flag_n", aff_n, 1'b0);
            chk("almost_empty_flag_n", aef_n, 1'b1);
            av(1'b0, 4'h8, 32'h0);
            chk("fill", rd[26:16], 36'h8);
            b_cs_n <= 1'b0;
            b_en <= 1'b1;
            for (int j = 0; j < 8 * n; j++) begin
                expq.push_back(pc(wq[j / n], j % n));
            end
            while (expq.size() > 7 * n + 1) @(posedge clock);
            if (n > 1) chk("full_flag_n", ff_n, 1'b0);
            while (expq.size() != 0) @(posedge clock);
            b_cs_n <= 1'b1;
            b_en <= 1'b0;
            repeat (3) @(posedge clock);
            chk("empty_flag_n", ef_n, 1'b0);
            chk("full_flag_n", ff_n, 1'b1);
            chk("almost_empty_flag_n", aef_n, 1'b0);
            #1 u_pa.send({1'b1, wq[0]});
            while (m1_n !== 1'b0) @(posedge clock);
            {b_cs_n, b_en, b_mail} <= 3'h3;
            @(posedge clock);
            {b_cs_n, b_en, b_mail} <= 3'h4;
            repeat (2) @(posedge clock);
            chk("mail_data", b_out, wq[0] & m);
            chk("a_to_b_mail_flag_n", m1_n, 1'b1);
        end
        close_out();
    end
endmodule

// ==== verif/bmf_port_a_model.sv ====
// Port A writer model: queues long words and mail, drives port A.
// Assumes the FIFO's full flag gates each FIFO write.
`timescale 1ns/1ps
module bmf_port_a_model (
    input  wire logic        clock,
    input  wire logic        full_flag_n,
    output logic             cs_n,
    output logic             en,
    output logic             mail,
    output logic      [35:0] data
);
    logic [36:0] q[$];
    task automatic send(input logic [36:0] e);
        q.push_back(e);
    endtask
    initial begin
        cs_n = 1'b1;
        en = 1'b0;
        mail = 1'b0;
        data = 36'h0;
    end
    // Hold each write until the edge that takes it
    always @(posedge clock) begin
        if (en && (mail || full_flag_n === 1'b1)) begin
            void'(q.pop_front());
        end
        cs_n <= (q.size() == 0);
        en <= (q.size() != 0);
        if (q.size() != 0) begin
            {mail, data} <= q[0];
        end else begin
            data <= ~data;
        end
    end
endmodule
